// ### src/prsed_pkg.sv
package prsed_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int GW = 31;
  localparam int DW = 19;
  localparam int ZIW = 29;
  localparam int ZWW = 16;
  localparam int CLK_HZ = 40_000_000;
  localparam int REGEN_MAX_PPS = 4_000_000;
  localparam int REGEN_GAP_INT = (CLK_HZ + REGEN_MAX_PPS - 1) / REGEN_MAX_PPS;
  localparam logic [7:0] REGEN_GAP = 8'(REGEN_GAP_INT);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_NUM1 = 8'h00;
  localparam logic [7:0] A_NUM2 = 8'h04;
  localparam logic [7:0] A_NUM3 = 8'h08;
  localparam logic [7:0] A_NUM4 = 8'h0c;
  localparam logic [7:0] A_GDEN = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_CTYPE = 8'h18;
  localparam logic [7:0] A_DNUM = 8'h1c;
  localparam logic [7:0] A_DDEN = 8'h20;
  localparam logic [7:0] A_ZMIN = 8'h24;
  localparam logic [7:0] A_ZINT = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2c;
  localparam logic [7:0] A_MASK = 8'h30;
  localparam logic [7:0] A_STATE = 8'h34;

  // Control register fields
  localparam int C_POS = 0;
  localparam int C_ENC = 2;
  localparam int C_ABM = 4;
  localparam int C_LIM = 5;
  localparam int C_DIR = 8;

  // Status bits
  localparam int S_LIM = 0;
  localparam int S_Z = 1;

  // Synchronised pin indices
  localparam int P_CP = 0;
  localparam int P_CD = 1;
  localparam int P_GL = 2;
  localparam int P_GH = 3;
  localparam int P_EA = 4;
  localparam int P_EB = 5;
  localparam int P_EZ = 6;
  localparam int P_E0 = 7;

  // Reset values and count weights
  localparam logic [GW-1:0] GEAR_RST = 31'h0000_0001;
  localparam logic [DW-1:0] DIV_RST = 19'h0_0001;
  localparam logic [3:0] CT_FULL_A = 4'h0;
  localparam logic [3:0] CT_FULL_B = 4'h2;

  typedef enum logic [1:0] {
    PRSED_ENC_ABS = 2'h0,
    PRSED_ENC_INC = 2'h1,
    PRSED_ENC_ABZ = 2'h2
  } prsed_enc_type_t;

  // Encoder side pins
  typedef struct packed {
    logic a;
    logic b;
    logic z;
    logic zero;
  } prsed_enc_t;

  // Regenerated quadrature output
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } prsed_regen_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] f;
    logic [7:0] fp;
    logic [3:0][GW-1:0] gnum;
    logic [GW-1:0] gden;
    logic [3:0] ctype;
    logic pos_mode;
    logic [1:0] enc_type;
    logic ab_method;
    logic lim_en;
    logic [1:0] dir_sel;
    logic [DW-1:0] dnum;
    logic [DW-1:0] dden;
    logic [ZWW-1:0] zmin;
    logic [ZIW-1:0] zint;
    logic [1:0] st;
    logic [1:0] mask;
    logic ph;
    logic [31:0] rdata;
    logic [33:0] gacc;
    logic cmd_out;
    logic cmd_dir;
    logic [31:0] dacc;
    logic [7:0] gap;
    logic [1:0] q;
    logic a_o;
    logic b_o;
    logic z_o;
    logic armed;
    logic [ZIW-1:0] zcnt;
    logic [ZWW-1:0] zst;
  } prsed_state_t;

endpackage : prsed_pkg

// ### src/prsed_top.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module prsed_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_pulse_in,
  input wire logic cmd_dir_in,
  input wire logic gear_select_low,
  input wire logic gear_select_high,
  input wire prsed_pkg::prsed_enc_t enc_in,
  output logic pos_cmd_pulse,
  output logic pos_cmd_dir,
  output prsed_pkg::prsed_regen_t regen_out,
  output logic regen_limit_error,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A zero ratio term would stall or flood the scaler, so it acts as one
  function automatic logic [prsed_pkg::GW-1:0] nz_g(input logic [prsed_pkg::GW-1:0] v);
    nz_g = (v == '0) ? prsed_pkg::GEAR_RST : v;
  endfunction : nz_g

  function automatic logic [prsed_pkg::DW-1:0] nz_d(input logic [prsed_pkg::DW-1:0] v);
    nz_d = (v == '0) ? prsed_pkg::DIV_RST : v;
  endfunction : nz_d

  // Quadrature position index: 00,01,10,11 in forward order
  function automatic logic [1:0] qidx(input logic a, input logic b);
    qidx = {a, a ^ b};
  endfunction : qidx

  function automatic logic mapped(input logic [7:0] ad);
    mapped = (ad[1:0] == 2'h0) && (ad <= prsed_pkg::A_STATE);
  endfunction : mapped

  prsed_pkg::prsed_state_t s_q;
  prsed_pkg::prsed_state_t s_d;

  logic acc_done;
  logic wr;
  logic [7:0] rise;
  logic [1:0] gsel;
  logic [prsed_pkg::GW-1:0] gnum;
  logic [prsed_pkg::GW-1:0] gden;
  logic [33:0] gadd;
  logic [33:0] gacc;
  logic [1:0] ip;
  logic [1:0] ic;
  logic in_step;
  logic in_fwd;
  logic signed [31:0] dacc;
  logic signed [31:0] dden;
  logic signed [31:0] dnum;
  logic lim_det;
  logic ab_pass;
  logic out_step;
  logic out_fwd;
  logic fwd_wrap;
  logic bwd_wrap;
  logic zev;
  logic [prsed_pkg::ZWW-1:0] zload;
  logic [1:0] ev;
  logic [1:0] clr;
  logic [31:0] rd;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle so prdata comes from a flop
  // With ce low the phase flop holds, so the access simply stretches
  assign pready = ce & s_q.ph;
  assign pslverr = psel & penable & pready & ~mapped(paddr);
  assign prdata = s_q.rdata;
  assign acc_done = psel & penable & pready;
  assign pos_cmd_pulse = s_q.cmd_out;
  assign pos_cmd_dir = s_q.cmd_dir;
  assign regen_out = '{a: s_q.a_o, b: s_q.b_o, z: s_q.z_o};
  assign regen_limit_error = s_q.st[prsed_pkg::S_LIM];
  assign irq = |(s_q.st & s_q.mask);

  always_comb begin
    rd = 32'h0000_0000;
    case (paddr)
      prsed_pkg::A_NUM1: rd = {1'b0, s_q.gnum[0]};
      prsed_pkg::A_NUM2: rd = {1'b0, s_q.gnum[1]};
      prsed_pkg::A_NUM3: rd = {1'b0, s_q.gnum[2]};
      prsed_pkg::A_NUM4: rd = {1'b0, s_q.gnum[3]};
      prsed_pkg::A_GDEN: rd = {1'b0, s_q.gden};
      prsed_pkg::A_CTRL: begin
        rd[prsed_pkg::C_POS] = s_q.pos_mode;
        rd[prsed_pkg::C_ENC +: 2] = s_q.enc_type;
        rd[prsed_pkg::C_ABM] = s_q.ab_method;
        rd[prsed_pkg::C_LIM] = s_q.lim_en;
        rd[prsed_pkg::C_DIR +: 2] = s_q.dir_sel;
      end
      prsed_pkg::A_CTYPE: rd = {28'h000_0000, s_q.ctype};
      prsed_pkg::A_DNUM: rd = {13'h0000, s_q.dnum};
      prsed_pkg::A_DDEN: rd = {13'h0000, s_q.dden};
      prsed_pkg::A_ZMIN: rd = {16'h0000, s_q.zmin};
      prsed_pkg::A_ZINT: rd = {3'h0, s_q.zint};
      prsed_pkg::A_STAT: rd = {30'h0000_0000, s_q.st};
      prsed_pkg::A_MASK: rd = {30'h0000_0000, s_q.mask};
      prsed_pkg::A_STATE: rd = {19'h0_0000, s_q.f, s_q.armed, s_q.z_o, s_q.b_o, s_q.a_o,
                               s_q.cmd_dir};
      default: rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr = acc_done & pwrite;
    rise = s_q.f & ~s_q.fp;
    gsel = 2'h0;
    gnum = '0;
    gden = '0;
    gadd = '0;
    gacc = '0;
    ip = 2'h0;
    ic = 2'h0;
    in_step = 1'b0;
    in_fwd = 1'b0;
    dacc = '0;
    dden = '0;
    dnum = '0;
    lim_det = 1'b0;
    ab_pass = 1'b0;
    out_step = 1'b0;
    out_fwd = 1'b0;
    fwd_wrap = 1'b0;
    bwd_wrap = 1'b0;
    zev = 1'b0;
    zload = '0;
    ev = 2'h0;
    clr = 2'h0;
    if (ce) begin
      // Pins: three stages, a change is taken once stages two and three agree
      s_d.s1 = {enc_in.zero, enc_in.z, enc_in.b, enc_in.a, gear_select_high,
                gear_select_low, cmd_dir_in, cmd_pulse_in};
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < 8; i++) begin
        s_d.f[i] = (s_q.s2[i] == s_q.s3[i]) ? s_q.s3[i] : s_q.f[i];
      end
      s_d.fp = s_q.f;

      // APB
      s_d.ph = psel & ~acc_done;
      if (psel && !s_q.ph) begin
        s_d.rdata = rd;
      end
      if (wr) begin
        case (paddr)
          prsed_pkg::A_NUM1: s_d.gnum[0] = pwdata[prsed_pkg::GW-1:0];
          prsed_pkg::A_NUM2: s_d.gnum[1] = pwdata[prsed_pkg::GW-1:0];
          prsed_pkg::A_NUM3: s_d.gnum[2] = pwdata[prsed_pkg::GW-1:0];
          prsed_pkg::A_NUM4: s_d.gnum[3] = pwdata[prsed_pkg::GW-1:0];
          prsed_pkg::A_GDEN: s_d.gden = pwdata[prsed_pkg::GW-1:0];
          prsed_pkg::A_CTRL: begin
            s_d.pos_mode = pwdata[prsed_pkg::C_POS];
            s_d.enc_type = pwdata[prsed_pkg::C_ENC +: 2];
            s_d.ab_method = pwdata[prsed_pkg::C_ABM];
            s_d.lim_en = pwdata[prsed_pkg::C_LIM];
            s_d.dir_sel = pwdata[prsed_pkg::C_DIR +: 2];
          end
          prsed_pkg::A_CTYPE: s_d.ctype = pwdata[3:0];
          prsed_pkg::A_DNUM: s_d.dnum = pwdata[prsed_pkg::DW-1:0];
          prsed_pkg::A_DDEN: s_d.dden = pwdata[prsed_pkg::DW-1:0];
          prsed_pkg::A_ZMIN: s_d.zmin = pwdata[prsed_pkg::ZWW-1:0];
          prsed_pkg::A_ZINT: s_d.zint = pwdata[prsed_pkg::ZIW-1:0];
          prsed_pkg::A_STAT: clr = pwdata[1:0];
          prsed_pkg::A_MASK: s_d.mask = pwdata[1:0];
          default: ;
        endcase
      end

      // ------------------------------------------------------------
      // Command pulse gear
      // ------------------------------------------------------------
      // numerator pair select
      gsel = {s_q.f[prsed_pkg::P_GH], s_q.f[prsed_pkg::P_GL]};
      gnum = nz_g(s_q.gnum[gsel]);
      gden = nz_g(s_q.gden);
      if (s_q.ctype == prsed_pkg::CT_FULL_A || s_q.ctype == prsed_pkg::CT_FULL_B) begin
        gadd = {1'b0, gnum, 2'b00};
      end else begin
        gadd = {2'b00, gnum, 1'b0};
      end
      s_d.cmd_dir = s_q.f[prsed_pkg::P_CD];
      s_d.cmd_out = 1'b0;
      if (!s_q.pos_mode) begin
        s_d.cmd_out = rise[prsed_pkg::P_CP];
        s_d.gacc = '0;
      end else begin
        // Pulses are paid out one per cycle; a large numerator over a small
        // denominator builds a backlog that drains one pulse per cycle, also while input pulses arrive
        // scaled output, one pulse per cycle while owed
        gacc = s_q.gacc;
        if (gacc >= {3'b000, gden}) begin
          s_d.cmd_out = 1'b1;
          gacc = gacc - {3'b000, gden};
        end
        if (rise[prsed_pkg::P_CP]) begin
          gacc = gacc + gadd;
        end
        s_d.gacc = gacc;
      end

      // ------------------------------------------------------------
      // Encoder divider
      // ------------------------------------------------------------
      ip = qidx(s_q.fp[prsed_pkg::P_EA], s_q.fp[prsed_pkg::P_EB]);
      ic = qidx(s_q.f[prsed_pkg::P_EA], s_q.f[prsed_pkg::P_EB]);
      in_fwd = (ic == ip + 2'h1);
      in_step = in_fwd || (ic == ip - 2'h1);
      dnum = $signed({13'h0000, nz_d(s_q.dnum)});
      dden = $signed({13'h0000, nz_d(s_q.dden)});
      // Codes two and three both mean an AB scale, so only the upper bit decides
      // method 0 on an AB scale skips regeneration
      ab_pass = s_q.enc_type[1] && !s_q.ab_method;
      dacc = $signed(s_q.dacc);
      // Spacing outputs by the gap caps the output rate; owed steps wait in the
      // accumulator instead of being dropped, which is what trips the limit check
      s_d.gap = (s_q.gap != 8'h00) ? s_q.gap - 8'h01 : 8'h00;
      if (!ab_pass) begin
        // unity ratio gives one step per input step
        if (s_q.gap == 8'h00 && dacc >= dden) begin
          out_step = 1'b1;
          out_fwd = 1'b1;
          dacc = dacc - dden;
        end else if (s_q.gap == 8'h00 && dacc <= -dden) begin
          out_step = 1'b1;
          dacc = dacc + dden;
        end
        if (in_step) begin
          dacc = in_fwd ? dacc + dnum : dacc - dnum;
        end
        // Backlog beyond one step means the output rate cannot keep up
        lim_det = (dacc >= (dden <<< 1)) || (dacc <= -(dden <<< 1));
      end else begin
        dacc = '0;
      end
      // remainder kept signed across direction changes
      s_d.dacc = dacc;
      if (out_step) begin
        s_d.gap = prsed_pkg::REGEN_GAP;
        s_d.q = out_fwd ? s_q.q + 2'h1 : s_q.q - 2'h1;
      end
      fwd_wrap = out_step && out_fwd && (s_q.q == 2'h3);
      bwd_wrap = out_step && !out_fwd && (s_q.q == 2'h0);
      if (ab_pass) begin
        s_d.a_o = s_q.f[prsed_pkg::P_EA];
        s_d.b_o = s_q.f[prsed_pkg::P_EB] ^ s_q.dir_sel[0];
      end else begin
        s_d.a_o = s_d.q[1];
        s_d.b_o = s_d.q[1] ^ s_d.q[0] ^ s_q.dir_sel[0];
      end

      // ------------------------------------------------------------
      // Phase Z
      // ------------------------------------------------------------
      // Outside AB scales, regenerated Z is never shorter than one output step gap
      zload = (s_q.zmin > {8'h00, prsed_pkg::REGEN_GAP}) ? s_q.zmin
                                                      : {8'h00, prsed_pkg::REGEN_GAP};
      case (s_q.enc_type)
        prsed_pkg::PRSED_ENC_ABS: begin
          if (rise[prsed_pkg::P_E0]) begin
            s_d.armed = 1'b1;
            s_d.zcnt = '0;
            zev = 1'b1;
          end else if (s_q.armed && s_q.zint != '0) begin
            // repeat every interval of A pulses
            if (fwd_wrap) begin
              s_d.zcnt = (s_q.zcnt == s_q.zint - 29'h1) ? '0 : s_q.zcnt + 29'h1;
              zev = (s_d.zcnt == '0);
            end else if (bwd_wrap) begin
              s_d.zcnt = (s_q.zcnt == '0) ? s_q.zint - 29'h1 : s_q.zcnt - 29'h1;
              zev = (s_q.zcnt == '0);
            end
          end
        end
        prsed_pkg::PRSED_ENC_INC: begin
          // undivided Z, as wide as zmin or one output step gap, whichever is larger
          zev = rise[prsed_pkg::P_EZ];
        end
        default: begin
          zev = rise[prsed_pkg::P_EZ];
          zload = s_q.zmin;
        end
      endcase
      // stretch counted from the leading edge
      if (zev) begin
        s_d.zst = zload;
      end else if (s_q.zst != '0) begin
        s_d.zst = s_q.zst - 16'h0001;
      end
      if (s_q.enc_type == prsed_pkg::PRSED_ENC_ABS || s_q.enc_type == prsed_pkg::PRSED_ENC_INC)
      begin
        s_d.z_o = (s_d.zst != '0);
      end else begin
        s_d.z_o = s_q.f[prsed_pkg::P_EZ] | (s_d.zst != '0);
      end

      // ------------------------------------------------------------
      // Status, set wins over write-one-to-clear
      // ------------------------------------------------------------
      // detection gated by the enable
      // raised on the first cycle of the limit
      ev[prsed_pkg::S_LIM] = s_q.lim_en & lim_det;
      ev[prsed_pkg::S_Z] = zev;
      s_d.st = (s_q.st & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.gnum <= {4{prsed_pkg::GEAR_RST}};
      s_q.gden <= prsed_pkg::GEAR_RST;
      s_q.dnum <= prsed_pkg::DIV_RST;
      s_q.dden <= prsed_pkg::DIV_RST;
      s_q.pos_mode <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : prsed_top

`default_nettype wire

// ### sim/prsed_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module prsed_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_pulse_in,
  input wire logic cmd_dir_in,
  input wire logic pos_cmd_pulse,
  input wire logic pos_cmd_dir,
  input wire prsed_pkg::prsed_regen_t regen_out,
  input wire logic regen_limit_error
);
  // --------
  // Helper
  // --------
  // Gear backlog is bounded, so scaled pulses must die out once input stops
  logic [9:0] idle_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 10'h3ff;
    end else if (cmd_pulse_in) begin
      idle_q <= 10'h000;
    end else if (idle_q != 10'h3ff) begin
      idle_q <= idle_q + 10'h001;
    end
  end
  // --------
  // Properties
  // --------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence z_min_hold;
    regen_out.z [*8] ##1 regen_out.z [*2];
  endsequence
  sequence dir_settled;
    $changed(cmd_dir_in) ##1 $stable(cmd_dir_in) [*6];
  endsequence
  rdy_in_access_a:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  err_with_rdy_a:
    assert property (pslverr |-> pready) else $error("slave error without ready");
  rdata_hold_a:
    assert property (pready |=> $stable(prdata)) else $error("read data moved");
  dir_follow_a:
    assert property (dir_settled |-> pos_cmd_dir == cmd_dir_in) else $error("dir not copied");
  cmd_drain_a:
    assert property (pos_cmd_pulse |-> idle_q < 10'h12c) else $error("pulse without input");
  quad_step_a:
    assert property (!($changed(regen_out.a) && $changed(regen_out.b))) else $error("a b together");
  step_gap_a:
    assert property ($changed(regen_out.a) |=> $stable(regen_out.a) [*8]) else $error("a too fast");
  z_width_a:
    assert property ($rose(regen_out.z) |-> z_min_hold) else $error("z too narrow");
  err_sticky_a:
    assert property (regen_limit_error && !(psel && pwrite) |=> regen_limit_error)
      else $error("limit error dropped");
endmodule : prsed_monitor

bind prsed_top prsed_monitor i_prsed_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_pulse_in(cmd_pulse_in),
  .cmd_dir_in(cmd_dir_in), .pos_cmd_pulse(pos_cmd_pulse), .pos_cmd_dir(pos_cmd_dir),
  .regen_out(regen_out), .regen_limit_error(regen_limit_error)
);
`default_nettype wire

// ### sim/prsed_enc_model.sv
`timescale 1ns/10ps
`default_nettype none
module prsed_enc_model (
  input wire logic pclk,
  output var prsed_pkg::prsed_enc_t enc
);
  logic [1:0] pos;
  initial begin
    enc = '0;
    pos = 2'h0;
  end
  // Forward quadrature steps, index {a,a^b} counting up
  task automatic step(input int n, input int gap);
    int g;
    g = (gap < 3) ? 3 : gap;
    repeat (n) begin
      repeat (g) @(posedge pclk);
      pos = pos + 2'h1;
      enc.a <= pos[1];
      enc.b <= pos[1] ^ pos[0];
    end
  endtask : step
  task automatic zpulse(input int w);
    @(posedge pclk);
    enc.z <= 1'b1;
    repeat (w) @(posedge pclk);
    enc.z <= 1'b0;
  endtask : zpulse
  task automatic zero_evt();
    @(posedge pclk);
    enc.zero <= 1'b1;
    repeat (4) @(posedge pclk);
    enc.zero <= 1'b0;
  endtask : zero_evt
endmodule : prsed_enc_model
`default_nettype wire

// ### sim/prsed_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module prsed_top_test;
  logic pclk, presetn, ce, psel, penable, pwrite, cmd_pulse_in, cmd_dir_in;
  logic gear_select_low, gear_select_high, pready, pslverr, pos_cmd_pulse, pos_cmd_dir;
  logic regen_limit_error, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sprev;
  prsed_pkg::prsed_enc_t enc_in;
  prsed_pkg::prsed_regen_t regen_out;
  int err_total, tests_run, pcnt, scnt, zr, zw, zrun;
  longint gacc, dacc;

  prsed_top i_prsed_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_pulse_in(cmd_pulse_in), .cmd_dir_in(cmd_dir_in),
    .gear_select_low(gear_select_low), .gear_select_high(gear_select_high), .enc_in(enc_in),
    .pos_cmd_pulse(pos_cmd_pulse), .pos_cmd_dir(pos_cmd_dir), .regen_out(regen_out),
    .regen_limit_error(regen_limit_error), .irq(irq));
  prsed_enc_model i_prsed_enc_model (.pclk(pclk), .enc(enc_in));

  always #12.5 pclk = ~pclk;

  // --------
  // Observers
  // --------
  always @(posedge pclk) begin
    if (pos_cmd_pulse === 1'b1) pcnt++;
    if ({regen_out.a, regen_out.b} !== sprev) scnt++;
    sprev = {regen_out.a, regen_out.b};
    if (regen_out.z === 1'b1) zrun++;
    else begin
      if (zrun > 0) begin
        zr++;
        zw = zrun;
      end
      zrun = 0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Read data and error are taken at the edge that completes the access
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask : apb

  task automatic cmd_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      cmd_pulse_in <= 1'b1;
      repeat (4) @(posedge pclk);
      cmd_pulse_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : cmd_pulses

  // Scaled count with remainder carried between calls
  function automatic int ratio_out(input int n, input longint inc, input longint den,
                                   inout longint acc);
    int k;
    k = 0;
    repeat (n) begin
      acc += inc;
      while (acc >= den) begin
        acc -= den;
        k++;
      end
    end
    return k;
  endfunction : ratio_out

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    longint nm [4];
    longint dn;
    int e, k, tot;
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; cmd_pulse_in = 0; cmd_dir_in = 0; gear_select_low = 0; gear_select_high = 0;
    err_total = 0; tests_run = 0; pcnt = 0; scnt = 0; zr = 0; zw = 0; zrun = 0;
    gacc = 0; dacc = 0; sprev = 0;
    void'($urandom(32'hbc448eda));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0);
      chk(rd, (i < 6 || i == 7 || i == 8) ? 32'h1 : 32'h0);
    end
    apb(8'h3c, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int t = 0; t < 16; t++) begin
      // Counted before the writes: a smaller denominator pays old remainder at once
      k = pcnt;
      for (int j = 0; j < 4; j++) begin
        nm[j] = (t == 15) ? 64'h4000_0000 : 64'(1 + $urandom % 7);
        apb(8'(4 * j), 1'b1, 32'(nm[j]));
      end
      dn = (t == 15) ? 64'h4000_0000 : 64'(1 + $urandom % 5);
      apb(prsed_pkg::A_GDEN, 1'b1, 32'(dn));
      apb(prsed_pkg::A_CTYPE, 1'b1, 32'(t / 4));
      gear_select_low <= t[0];
      gear_select_high <= t[1];
      cmd_dir_in <= 1'($urandom);
      repeat (8) @(posedge pclk);
      e = ratio_out(6, nm[t % 4] * ((t / 4) % 2 == 0 ? 4 : 2), dn, gacc);
      cmd_pulses(6);
      repeat (200) @(posedge pclk);
      chk(pcnt - k, e);
      chk(32'(pos_cmd_dir), 32'(cmd_dir_in));
    end
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h0);
    k = pcnt;
    cmd_pulses(5);
    repeat (20) @(posedge pclk);
    chk(pcnt - k, 5);
    $display("test gear done");
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h9);
    repeat (8) @(posedge pclk);
    k = scnt;
    i_prsed_enc_model.step(3, 12);
    repeat (20) @(posedge pclk);
    chk({regen_out.a, regen_out.b}, {enc_in.a, enc_in.b});
    i_prsed_enc_model.step(1, 12);
    repeat (20) @(posedge pclk);
    chk(scnt - k, 4);
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h1);
    k = scnt;
    i_prsed_enc_model.step(10, 12);
    repeat (30) @(posedge pclk);
    chk(scnt - k, 10);
    tot = 10;
    for (int r = 0; r < 2; r++) begin
      nm[0] = 64'(1 + $urandom % 4);
      dn = nm[0] + 64'($urandom % 4);
      k = scnt;
      apb(prsed_pkg::A_DNUM, 1'b1, 32'(nm[0]));
      apb(prsed_pkg::A_DDEN, 1'b1, 32'(dn));
      e = ratio_out(12, nm[0], dn, dacc);
      i_prsed_enc_model.step(12, 12);
      repeat (30) @(posedge pclk);
      chk(scnt - k, e);
      tot += e;
    end
    for (int d = 0; d < 4; d++) begin
      apb(prsed_pkg::A_CTRL, 1'b1, 32'h1 | 32'(d << 8));
      repeat (8) @(posedge pclk);
      chk({regen_out.a, regen_out.b}, {tot[1], tot[1] ^ tot[0] ^ d[0]});
    end
    $display("test divider done");
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h1);
    apb(prsed_pkg::A_DNUM, 1'b1, 32'h1);
    apb(prsed_pkg::A_DDEN, 1'b1, 32'h1);
    i_prsed_enc_model.step(24, 3);
    chk(32'(regen_limit_error), 32'h0);
    repeat (400) @(posedge pclk);
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h21);
    i_prsed_enc_model.step(24, 3);
    chk(32'(regen_limit_error), 32'h1);
    apb(prsed_pkg::A_MASK, 1'b1, 32'h1);
    chk(32'(irq), 32'h1);
    apb(prsed_pkg::A_MASK, 1'b1, 32'h0);
    chk(32'(irq), 32'h0);
    repeat (400) @(posedge pclk);
    apb(prsed_pkg::A_STAT, 1'b0, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(prsed_pkg::A_STAT, 1'b1, 32'h1);
    chk(32'(regen_limit_error), 32'h0);
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h1);
    $display("test limit done");
    i_prsed_enc_model.zpulse(4);
    repeat (30) @(posedge pclk);
    chk(zr, 0);
    apb(prsed_pkg::A_ZINT, 1'b1, 32'h2);
    apb(prsed_pkg::A_ZMIN, 1'b1, 32'h14);
    i_prsed_enc_model.zero_evt();
    repeat (40) @(posedge pclk);
    chk(zr, 1);
    chk(zw, 20);
    i_prsed_enc_model.step(16, 12);
    repeat (40) @(posedge pclk);
    chk(zr, 3);
    apb(prsed_pkg::A_ZMIN, 1'b1, 32'h0);
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h5);
    i_prsed_enc_model.zpulse(4);
    repeat (30) @(posedge pclk);
    chk(zr, 4);
    chk(zw, 10);
    apb(prsed_pkg::A_ZMIN, 1'b1, 32'h10);
    apb(prsed_pkg::A_CTRL, 1'b1, 32'h19);
    for (int w = 4; w < 40; w += 26) begin
      i_prsed_enc_model.zpulse(w);
      repeat (50) @(posedge pclk);
      chk(zw, (w > 16) ? w : 16);
    end
    $display("test z done");
    report_and_stop();
  end
endmodule : prsed_top_test
`default_nettype wire
